// ===== design/gct_pkg.sv
// Package for the gated capture timer: register map, fields and types
package gct_pkg;
    // Register byte offsets on the APB port
    localparam logic [7:0] GCT_CNT_HI = 8'h00;
    localparam logic [7:0] GCT_CNT_LO = 8'h04;
    localparam logic [7:0] GCT_RLD_HI = 8'h08;
    localparam logic [7:0] GCT_RLD_LO = 8'h0c;
    localparam logic [7:0] GCT_CTL = 8'h10;
    localparam logic [7:0] GCT_STS = 8'h14;
    localparam logic [7:0] GCT_MSK = 8'h18;
    localparam logic [7:0] GCT_PIN = 8'h1c;

    // Values after reset and the restart count
    localparam logic [15:0] GCT_CNT_RST = 16'h0000;
    localparam logic [15:0] GCT_RLD_RST = 16'hffff;
    localparam logic [15:0] GCT_RESTART = 16'h0001;
    localparam logic [15:0] GCT_ONE = 16'h0001;
    localparam logic [7:0] GCT_CTL_RST = 8'h00;
    localparam logic [7:0] GCT_HOLD_RST = 8'h00;

    // Interrupt status bit positions and width
    localparam int GCT_IRQ_RLD = 0;
    localparam int GCT_IRQ_GATE = 1;
    localparam int GCT_IRQ_ARM = 2;
    localparam int GCT_IRQ_W = 3;
    localparam logic [GCT_IRQ_W-1:0] GCT_IRQ_RST = 3'h0;

    // Prescaler counter width (divide by 1 to 128)
    localparam int GCT_PRE_W = 7;

    // Counting modes
    typedef enum logic [1:0] {
        GCT_CONT,
        GCT_GATED,
        GCT_CAPCMP,
        GCT_COMPARE
    } gct_mode_t;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic enable;
        logic polarity;
        logic [2:0] prescale;
        logic out_en;
        gct_mode_t mode;
    } gct_ctl_t;

    // Start state for capture/compare mode
    typedef enum logic {
        GCT_ARM_WAIT,
        GCT_ARM_RUN
    } gct_arm_t;
endpackage : gct_pkg

// ===== design/gct_prescaler.sv
// Power-of-two prescaler producing one tick per divided period
`timescale 1ns/10ps
module gct_prescaler
    import gct_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Run permission and divide exponent
    input wire logic run,
    input wire logic [2:0] prescale,
    // One-cycle tick
    output logic tick
);
    logic [GCT_PRE_W-1:0] div_q;
    logic [GCT_PRE_W-1:0] lim;

    // Last count of a period is the factor minus one
    assign lim = GCT_PRE_W'((8'h01 << prescale) - 8'h01);
    assign tick = run && (div_q == lim);

    // Phase restarts whenever counting is not permitted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else if (!run || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
endmodule : gct_prescaler

// ===== design/gct_sync.sv
// Two-flop synchroniser for the timer input pin
`timescale 1ns/10ps
module gct_sync
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous level in, synchronised level out
    input wire logic d,
    output logic q
);
    logic meta_q;

    // First flop feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : gct_sync

// ===== design/gct_timer.sv
// Gated capture timer: APB registers, counter, gating and interrupts
`timescale 1ns/10ps
//
// Function
// - Gated mode counts only while input asserted
// - Gated interrupt on deassertion or reload
// - Reaching reload interrupts and restarts at 0001H
// - Start count applies to first gated pass
// - Output pin toggles on each reload
// - Capture/compare waits for first input edge
// - Compare time is difference times prescale factor
// - Coherent 16-bit count read while enabled
// - Disabled low byte read returns live count
// - High byte read latches low byte copy while enabled
// - Count byte writes load at next edge
module gct_timer
    import gct_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer pins
    input wire logic tmr_in,
    output logic tmr_out,
    output logic tmr_out_oe,
    // Interrupt
    output logic irq
);
    gct_ctl_t ctl_q;
    gct_arm_t arm_q;
    logic [15:0] cnt_q;
    logic [15:0] rld_q;
    logic [15:0] cnt_inc;
    logic [7:0] hold_q;
    logic [GCT_IRQ_W-1:0] sts_q;
    logic [GCT_IRQ_W-1:0] msk_q;
    logic [GCT_IRQ_W-1:0] sts_set;
    logic [GCT_IRQ_W-1:0] sts_clr;
    logic [31:0] rdata_q;
    logic err_q;
    logic out_q;
    logic in_s;
    logic in_p_q;
    logic act;
    logic act_p;
    logic edge_hit;
    logic run;
    logic tick;
    logic rld_hit;
    logic evt_rld;
    logic evt_gate;
    logic evt_arm;
    logic setup;
    logic acc;
    logic wr;
    logic wr_hi;
    logic wr_lo;
    logic cnt_wr;
    logic rd_hi;
    logic gated;

    // Input synchroniser and previous level
    gct_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(tmr_in),
        .q(in_s)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_p_q <= 1'b0;
        end else begin
            in_p_q <= in_s;
        end
    end

    // Input polarity decode
    assign act = ctl_q.polarity ? in_s : ~in_s;
    assign act_p = ctl_q.polarity ? in_p_q : ~in_p_q;
    assign edge_hit = act && !act_p;
    assign gated = ctl_q.enable && (ctl_q.mode == GCT_GATED);

    // APB phase decode
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign wr_hi = wr && (paddr == GCT_CNT_HI);
    assign wr_lo = wr && (paddr == GCT_CNT_LO);
    assign cnt_wr = wr_hi || wr_lo;
    // High byte and low byte copy taken at the same edge, so no rollover tears them
    assign rd_hi = setup && !pwrite && (paddr == GCT_CNT_HI);
    assign pready = 1'b1;
    assign pslverr = err_q && acc;
    assign prdata = rdata_q;

    // Read data latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
            err_q <= 1'b0;
        end else if (setup) begin
            err_q <= 1'b0;
            rdata_q <= '0;
            case (paddr)
                GCT_CNT_HI: rdata_q[7:0] <= cnt_q[15:8];
                GCT_CNT_LO: begin
                    // Held copy while enabled, live byte otherwise
                    rdata_q[7:0] <= ctl_q.enable ? hold_q : cnt_q[7:0];
                end
                GCT_RLD_HI: rdata_q[7:0] <= rld_q[15:8];
                GCT_RLD_LO: rdata_q[7:0] <= rld_q[7:0];
                GCT_CTL: rdata_q[7:0] <= ctl_q;
                GCT_STS: rdata_q[GCT_IRQ_W-1:0] <= sts_q;
                GCT_MSK: rdata_q[GCT_IRQ_W-1:0] <= msk_q;
                GCT_PIN: rdata_q[2:0] <= {arm_q == GCT_ARM_RUN, out_q, in_s};
                default: err_q <= 1'b1;
            endcase
        end
    end

    // Control, reload and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= gct_ctl_t'(GCT_CTL_RST);
            rld_q <= GCT_RLD_RST;
            msk_q <= GCT_IRQ_RST;
        end else if (wr) begin
            case (paddr)
                GCT_CTL: ctl_q <= gct_ctl_t'(pwdata[7:0]);
                GCT_RLD_HI: rld_q[15:8] <= pwdata[7:0];
                GCT_RLD_LO: rld_q[7:0] <= pwdata[7:0];
                GCT_MSK: msk_q <= pwdata[GCT_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Low byte copy taken on a high byte read while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= GCT_HOLD_RST;
        end else if (rd_hi && ctl_q.enable) begin
            hold_q <= cnt_q[7:0];
        end
    end

    // Capture/compare start: wait for the selected edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_q <= GCT_ARM_WAIT;
        end else if (!ctl_q.enable || ctl_q.mode != GCT_CAPCMP) begin
            arm_q <= GCT_ARM_WAIT;
        end else begin
            case (arm_q)
                GCT_ARM_WAIT: if (edge_hit) arm_q <= GCT_ARM_RUN;
                GCT_ARM_RUN: arm_q <= GCT_ARM_RUN;
                default: arm_q <= GCT_ARM_WAIT;
            endcase
        end
    end
    assign evt_arm = ctl_q.enable && (ctl_q.mode == GCT_CAPCMP)
        && (arm_q == GCT_ARM_WAIT) && edge_hit;

    // Counting permission per mode
    always_comb begin
        run = 1'b0;
        if (ctl_q.enable) begin
            case (ctl_q.mode)
                GCT_GATED: run = act;
                GCT_CAPCMP: run = (arm_q == GCT_ARM_RUN);
                GCT_CONT: run = 1'b1;
                GCT_COMPARE: run = 1'b1;
                default: run = 1'b0;
            endcase
        end
    end

    gct_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .prescale(ctl_q.prescale),
        .tick(tick)
    );

    // Reload detect on the increment that would reach the reload value
    assign cnt_inc = cnt_q + GCT_ONE;
    assign rld_hit = (cnt_inc == rld_q);
    assign evt_rld = tick && rld_hit && !cnt_wr;
    assign evt_gate = gated && act_p && !act;

    // Counter: byte writes win, then reload restart, else one step per tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= GCT_CNT_RST;
        end else if (cnt_wr) begin
            if (wr_hi) cnt_q[15:8] <= pwdata[7:0];
            if (wr_lo) cnt_q[7:0] <= pwdata[7:0];
        end else if (evt_rld) begin
            cnt_q <= GCT_RESTART;
        end else if (tick) begin
            cnt_q <= cnt_inc;
        end
    end

    // Output pin toggles at each reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
        end else if (evt_rld && ctl_q.out_en) begin
            out_q <= ~out_q;
        end
    end
    assign tmr_out = out_q;
    assign tmr_out_oe = ctl_q.out_en;

    // Sticky status, write one to clear, set wins
    assign sts_set = {evt_arm, evt_gate, evt_rld};
    assign sts_clr = (wr && paddr == GCT_STS) ? pwdata[GCT_IRQ_W-1:0] : GCT_IRQ_RST;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= GCT_IRQ_RST;
        end else begin
            sts_q <= (sts_q & ~sts_clr) | sts_set;
        end
    end
    assign irq = |(sts_q & msk_q);

    // Helper: cycles since the last tick of an unbroken run
    logic [7:0] gap_q;
    logic gap_ok_q;
    logic [7:0] fac;
    assign fac = 8'h01 << ctl_q.prescale;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= '0;
            gap_ok_q <= 1'b0;
        end else if (!run) begin
            gap_q <= '0;
            gap_ok_q <= 1'b0;
        end else if (tick) begin
            gap_q <= '0;
            gap_ok_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 8'h01;
        end
    end

    // Properties
    property p_gate_hold;
        @(posedge pclk) disable iff (!presetn)
        (gated && !act && !cnt_wr) |=> (cnt_q == $past(cnt_q));
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gated count moved");

    property p_gate_irq;
        @(posedge pclk) disable iff (!presetn)
        (gated && act_p && !act) |=> sts_q[GCT_IRQ_GATE];
    endproperty
    a_gate_irq: assert property (p_gate_irq) else $error("no gate-off flag");

    property p_reload;
        @(posedge pclk) disable iff (!presetn)
        (tick && rld_hit && !cnt_wr) |=> (cnt_q == GCT_RESTART) && sts_q[GCT_IRQ_RLD];
    endproperty
    a_reload: assert property (p_reload) else $error("reload restart wrong");

    property p_next_pass;
        @(posedge pclk) disable iff (!presetn)
        (evt_rld && gated) ##1 (tick && !rld_hit && !cnt_wr) |=> (cnt_q == 16'h0002);
    endproperty
    a_next_pass: assert property (p_next_pass) else $error("pass not from one");

    property p_out_toggle;
        @(posedge pclk) disable iff (!presetn)
        (evt_rld && ctl_q.out_en) |=> (tmr_out != $past(tmr_out));
    endproperty
    a_out_toggle: assert property (p_out_toggle) else $error("output not toggled");

    property p_arm_wait;
        @(posedge pclk) disable iff (!presetn)
        (ctl_q.mode == GCT_CAPCMP && arm_q == GCT_ARM_WAIT && !cnt_wr)
            |=> $stable(cnt_q);
    endproperty
    a_arm_wait: assert property (p_arm_wait) else $error("counted before edge");

    property p_tick_gap;
        @(posedge pclk) disable iff (!presetn)
        (tick && gap_ok_q && $stable(ctl_q.prescale)) |-> (gap_q + 8'h01 == fac);
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");

    property p_step;
        @(posedge pclk) disable iff (!presetn)
        (tick && !rld_hit && !cnt_wr) |=> (cnt_q == $past(cnt_inc));
    endproperty
    a_step: assert property (p_step) else $error("no step on tick");

    property p_rd_held;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == GCT_CNT_LO && ctl_q.enable)
            |=> (prdata[7:0] == $past(hold_q));
    endproperty
    a_rd_held: assert property (p_rd_held) else $error("low read not held");

    property p_rd_live;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == GCT_CNT_LO && !ctl_q.enable)
            |=> (prdata[7:0] == $past(cnt_q[7:0]));
    endproperty
    a_rd_live: assert property (p_rd_live) else $error("low read not live");

    property p_hold_copy;
        @(posedge pclk) disable iff (!presetn)
        (rd_hi && ctl_q.enable) |=> (hold_q == $past(cnt_q[7:0]));
    endproperty
    a_hold_copy: assert property (p_hold_copy) else $error("copy not taken");

    property p_coherent;
        @(posedge pclk) disable iff (!presetn)
        (rd_hi && ctl_q.enable) |=> ({prdata[7:0], hold_q} == $past(cnt_q));
    endproperty
    a_coherent: assert property (p_coherent) else $error("count read torn");

    property p_wr_lo;
        @(posedge pclk) disable iff (!presetn)
        wr_lo |=> (cnt_q[7:0] == $past(pwdata[7:0]));
    endproperty
    a_wr_lo: assert property (p_wr_lo) else $error("low write lost");

    // Main scenarios
    c_gated_reload: cover property (@(posedge pclk) disable iff (!presetn) evt_rld && gated);
    c_gate_off: cover property (@(posedge pclk) disable iff (!presetn) evt_gate);
    c_arm: cover property (@(posedge pclk) disable iff (!presetn) evt_arm);
endmodule : gct_timer

// ===== test/gct_pin_model.sv
// Far-side model: drives the timer input pin and watches the output pin
`timescale 1ns/10ps
module gct_pin_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench commands
    input wire logic gate_req,
    input wire logic gate_pol,
    // Timer pins
    input wire logic tmr_out,
    input wire logic tmr_out_oe,
    output logic tmr_in,
    // Toggle count seen on the driven output
    output logic [7:0] toggles
);
    logic last_q;

    // Input only goes active when the bench commands it, after setup
    always_ff @(posedge pclk) begin
        tmr_in <= gate_pol ? gate_req : !gate_req;
    end

    // Count output edges while the pin is driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 1'b0;
            toggles <= 8'h00;
        end else begin
            last_q <= tmr_out;
            if (tmr_out_oe && tmr_out !== last_q) begin
                toggles <= toggles + 8'h01;
            end
        end
    end
endmodule : gct_pin_model

// ===== test/gct_timer_tb.sv
// Self-checking bench for the gated capture timer
`timescale 1ns/10ps
module gct_timer_tb;
    import gct_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic tmr_in, tmr_out, tmr_out_oe, irq, err_seen, gate_req, gate_pol;
    logic [7:0] paddr, toggles;
    logic [31:0] pwdata, prdata, rd, v1, v2;
    int err_count, n_tests, cyc, w;

    gct_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tmr_in(tmr_in), .tmr_out(tmr_out), .tmr_out_oe(tmr_out_oe),
        .irq(irq));
    gct_pin_model i_pin (.pclk(pclk), .presetn(presetn), .gate_req(gate_req),
        .gate_pol(gate_pol), .tmr_out(tmr_out), .tmr_out_oe(tmr_out_oe), .tmr_in(tmr_in),
        .toggles(toggles));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = !pclk;
    end

    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] ctl(logic e, logic p, logic [2:0] s, logic o, gct_mode_t m);
        gct_ctl_t c;
        c = '{enable: e, polarity: p, prescale: s, out_en: o, mode: m};
        return {24'h0, c};
    endfunction : ctl

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer, waits for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Wait ends once pready is high; the hang guard ends it if pready never rises
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask : rdchk

    task automatic poll(input string nm, input logic [7:0] a, input int b);
        w = 0;
        rd = 32'h0;
        while (rd[b] !== 1'b1 && w < 200) begin
            apb(1'b0, a, 32'h0);
            w++;
        end
        chk(nm, 32'h1, {31'h0, rd[b]});
    endtask : poll

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        {psel, penable, pwrite, gate_req, gate_pol} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped address
        rdchk("cnt_hi", GCT_CNT_HI, 32'h0);
        rdchk("rld_hi", GCT_RLD_HI, 32'hff);
        rdchk("rld_lo", GCT_RLD_LO, 32'hff);
        rdchk("ctl", GCT_CTL, 32'h0);
        rdchk("unmapped", 8'h20, 32'h0);
        chk("slverr", 32'h1, {31'h0, err_seen});
        // Gated, active-low input, divide by 128, start 3, reload 5
        apb(1'b1, GCT_CTL, ctl(1'b0, 1'b0, 3'h7, 1'b1, GCT_GATED));
        apb(1'b1, GCT_CNT_HI, 32'h0);
        apb(1'b1, GCT_CNT_LO, 32'h3);
        apb(1'b1, GCT_RLD_HI, 32'h0);
        apb(1'b1, GCT_RLD_LO, 32'h5);
        apb(1'b1, GCT_MSK, 32'h3);
        apb(1'b1, GCT_CTL, ctl(1'b1, 1'b0, 3'h7, 1'b1, GCT_GATED));
        chk("out_oe", 32'h1, {31'h0, tmr_out_oe});
        repeat (300) @(posedge pclk);
        rdchk("idle_hi", GCT_CNT_HI, 32'h0);
        rdchk("idle_lo", GCT_CNT_LO, 32'h3);
        gate_req <= 1'b1;
        poll("reload_sts", GCT_STS, GCT_IRQ_RLD);
        chk("reload_irq", 32'h1, {31'h0, irq});
        rdchk("restart_hi", GCT_CNT_HI, 32'h0);
        rdchk("restart_lo", GCT_CNT_LO, 32'h1);
        chk("toggles", 32'h1, {24'h0, toggles});
        apb(1'b1, GCT_STS, 32'h1);
        @(posedge pclk);
        chk("irq_clear", 32'h0, {31'h0, irq});
        gate_req <= 1'b0;
        poll("gate_sts", GCT_STS, GCT_IRQ_GATE);
        chk("gate_irq", 32'h1, {31'h0, irq});
        // Not started, output toggled once, pin high against active-low polarity
        rdchk("pin_vs_pol", GCT_PIN, 32'h3);
        apb(1'b0, GCT_CNT_HI, 32'h0);
        apb(1'b0, GCT_CNT_LO, 32'h0);
        v1 = rd;
        repeat (300) @(posedge pclk);
        apb(1'b0, GCT_CNT_HI, 32'h0);
        rdchk("frozen", GCT_CNT_LO, v1);
        apb(1'b1, GCT_MSK, 32'h0);
        @(posedge pclk);
        chk("masked", 32'h0, {31'h0, irq});
        apb(1'b1, GCT_STS, 32'h7);
        // Capture/compare waits for the first rising edge
        gate_pol <= 1'b1;
        apb(1'b1, GCT_CTL, 32'h0);
        apb(1'b1, GCT_CNT_LO, 32'h0);
        apb(1'b1, GCT_RLD_HI, 32'hff);
        apb(1'b1, GCT_MSK, 32'h4);
        apb(1'b1, GCT_CTL, ctl(1'b1, 1'b1, 3'h0, 1'b0, GCT_CAPCMP));
        repeat (50) @(posedge pclk);
        rdchk("wait_hi", GCT_CNT_HI, 32'h0);
        rdchk("wait_lo", GCT_CNT_LO, 32'h0);
        gate_req <= 1'b1;
        poll("arm_sts", GCT_STS, GCT_IRQ_ARM);
        repeat (20) @(posedge pclk);
        apb(1'b0, GCT_CNT_HI, 32'h0);
        apb(1'b0, GCT_CNT_LO, 32'h0);
        chk("started", 32'h1, {31'h0, rd != 32'h0});
        // Compare: start 0x10, compare 0x18, divide by 4
        apb(1'b1, GCT_CTL, 32'h0);
        apb(1'b1, GCT_STS, 32'h7);
        apb(1'b1, GCT_CNT_LO, 32'h10);
        apb(1'b1, GCT_RLD_HI, 32'h0);
        apb(1'b1, GCT_RLD_LO, 32'h18);
        apb(1'b1, GCT_MSK, 32'h1);
        apb(1'b1, GCT_CTL, ctl(1'b1, 1'b0, 3'h2, 1'b0, GCT_COMPARE));
        w = 0;
        while (irq !== 1'b1 && w < 100) begin
            @(posedge pclk);
            w++;
        end
        chk("cmp_time", 32'h1, {31'h0, w >= 32 && w <= 33});
        // Live low byte while disabled, held copy while enabled
        apb(1'b1, GCT_CTL, 32'h0);
        apb(1'b1, GCT_CNT_LO, 32'hf0);
        rdchk("live_lo", GCT_CNT_LO, 32'hf0);
        apb(1'b1, GCT_CTL, ctl(1'b1, 1'b0, 3'h0, 1'b0, GCT_CONT));
        rdchk("coh_hi", GCT_CNT_HI, 32'h0);
        apb(1'b0, GCT_CNT_LO, 32'h0);
        v2 = rd;
        repeat (10) @(posedge pclk);
        rdchk("held_lo", GCT_CNT_LO, v2);
        // Byte write while counting loads at once
        apb(1'b1, GCT_CTL, 32'h0);
        apb(1'b1, GCT_CNT_LO, 32'h0);
        apb(1'b1, GCT_CTL, ctl(1'b1, 1'b0, 3'h7, 1'b0, GCT_CONT));
        apb(1'b1, GCT_CNT_HI, 32'h55);
        rdchk("wr_hi", GCT_CNT_HI, 32'h55);
        tally_and_finish();
    end
endmodule : gct_timer_tb
